// *** verilog/sic_indexer.sv ***
// Purpose: Indexer, step input, standstill current and stall logic of a two-phase stepper driver.
// Assumes: Classic Wishbone slave on clk; torque samples arrive from logic on clk.
// Notes: Registers are 1 to 12 bits wide in the low bits of each word; upper bits read zero, except that positions read sign-extended.
// Summary of operation
// [R01] Standstill hold current defaults to fifty percent.
// [R02] Hold percentage never below one percent.
// [R03] Position runs 0,255,0,-255,0 and repeats.
// [R04] Separate positions kept for phases A, B.
// [R05] Indexer reset homes both, then self-clears.
// [R06] Indexer reset touches no other register; the code also sets the IDXRST interrupt status bit.
// [R07] Phase A scaler: 10 bits, split high/low.
// [R08] Scaler 1023 means maximum phase current.
// [R09] Scaler ignores torque and hold settings.
// [R10] Auto-microstepping interpolates each step pulse.
// [R11] Rising-only or both-edge stepping, rising default.
// [R12] Source halves pulse rate for both edges.
// [R13] Stall threshold learned or written manually.
// [R14] Hold current after delay, ramp over fall.
//
// The address map and the Wishbone register port were decided locally.
`timescale 1ns/1ps
`include "sic_params.svh"
module sic_indexer #(
   parameter int MS_CYC = `SIC_MS_CYC
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic step_pin,
   input wire logic dir_pin,
   input wire logic [11:0] torque_count,
   input wire logic torque_valid,
   output sic_pkg::sic_pos_t pos_a,
   output sic_pkg::sic_pos_t pos_b,
   output logic [9:0] phase_a_mag,
   output logic [9:0] phase_b_mag,
   output logic [6:0] current_pct,
   output logic stall,
   output logic irq
);
   import sic_pkg::*;

   // One electrical cycle is folded into a 0..1019 table index.
   function automatic sic_pos_t pos_of(input logic [9:0] k);
      int t;
      int r;
      t = int'(k);
      if (t <= 255) begin
         r = t;
      end else if (t <= 765) begin
         r = 510 - t;
      end else begin
         r = t - 1020;
      end
      return sic_pos_t'(r);
   endfunction

   // Parabolic magnitude: exactly 1023 at |pos| 255, 0 at pos 0.
   function automatic logic [9:0] mag_of(input sic_pos_t p);
      int x;
      x = (p < 0) ? -int'(p) : int'(p);
      return 10'((x * (510 - x) * 4092) / 260100);
   endfunction

   function automatic logic [9:0] kmove(input logic [9:0] k, input logic [9:0] amt, input logic fwd);
      logic [10:0] s;
      s = 11'h000;
      if (fwd) begin
         s = {1'b0, k} + {1'b0, amt};
         if (s >= {1'b0, `SIC_IDX_PERIOD}) begin
            s = s - {1'b0, `SIC_IDX_PERIOD};
         end
      end else begin
         s = {1'b0, k} + {1'b0, `SIC_IDX_PERIOD} - {1'b0, amt};
         if (s >= {1'b0, `SIC_IDX_PERIOD}) begin
            s = s - {1'b0, `SIC_IDX_PERIOD};
         end
      end
      return s[9:0];
   endfunction

   localparam logic [19:0] MS_CYC_W = 20'(MS_CYC);
   localparam logic [19:0] FALL_UNIT = 20'(`SIC_FALL_UNIT_CYC);

   logic step_evt;
   logic dir_s;

   // Register file state.
   logic [7:0] ctrl_r, ctrl_nxt;
   logic [6:0] hold_r, hold_nxt;
   logic [7:0] ssdly_r, ssdly_nxt;
   logic [7:0] ssfall_r, ssfall_nxt;
   logic [11:0] thr_r, thr_nxt;
   logic [2:0] mode_r, mode_nxt;
   logic learn_go_r, learn_go_nxt;
   logic [3:0] istat_r, istat_nxt;
   logic [3:0] ien_r, ien_nxt;
   logic ack_r, ack_nxt;
   logic [31:0] dat_r, dat_nxt;
   logic irq_r, irq_nxt;

   // Motion state.
   logic [9:0] k_r, k_nxt;
   logic dir_r, dir_nxt;
   logic [15:0] per_r, per_nxt;
   logic [15:0] ivl_r, ivl_nxt;
   logic [15:0] sub_r, sub_nxt;
   logic [2:0] rem_r, rem_nxt;
   sic_ss_e ss_r, ss_nxt;
   logic [19:0] cyc_r, cyc_nxt;
   logic [7:0] idle_r, idle_nxt;
   logic [6:0] pct_r, pct_nxt;
   logic [11:0] lthr_r, lthr_nxt;
   logic stall_r, stall_nxt;
   sic_pos_t pa_r, pa_nxt;
   sic_pos_t pb_r, pb_nxt;
   logic [9:0] ma_r, ma_nxt;
   logic [9:0] mb_r, mb_nxt;

   logic wr;
   logic rd;
   logic [3:0] evt;
   logic [11:0] thr_use;
   logic [1:0] ares;
   logic [9:0] base_inc;
   logic [9:0] fine_inc;
   logic [9:0] kb;

   sic_step_in u_step (
      .clk(clk),
      .rst_n(rst_n),
      .step_pin(step_pin),
      .dir_pin(dir_pin),
      .both_edges(ctrl_r[`SIC_CTRL_BOTH]),
      .step_evt(step_evt),
      .dir_s(dir_s)
   );

   assign wr = wb_cyc_i & wb_stb_i & wb_we_i & ~ack_r;
   assign rd = wb_cyc_i & wb_stb_i & ~wb_we_i & ~ack_r;
   assign ares = ctrl_r[`SIC_CTRL_ARES_LO +: 2];
   // Resolution code 7 is the finest step, one table entry per pulse unless auto substeps add 2^ares - 1 more.
   assign base_inc = 10'h080 >> mode_r;
   assign fine_inc = ((base_inc >> ares) == 10'h000) ? 10'h001 : (base_inc >> ares);
   // Learned threshold while learning is enabled, the written value otherwise.
   assign thr_use = ctrl_r[`SIC_CTRL_LEARNEN] ? lthr_r : thr_r; // [R13]

   always_comb begin
      ctrl_nxt = ctrl_r;
      hold_nxt = hold_r;
      ssdly_nxt = ssdly_r;
      ssfall_nxt = ssfall_r;
      thr_nxt = thr_r;
      mode_nxt = mode_r;
      learn_go_nxt = learn_go_r;
      ien_nxt = ien_r;
      ack_nxt = wb_cyc_i & wb_stb_i & ~ack_r;
      dat_nxt = 32'h0000_0000;
      // The indexer reset bit drops the cycle after it acted.
      ctrl_nxt[`SIC_CTRL_IDXRST] = 1'b0; // [R05]
      if (learn_go_r && torque_valid) begin
         learn_go_nxt = 1'b0;
      end
      istat_nxt = istat_r;
      if (wr && wb_sel_i[0]) begin
         unique case (wb_adr_i)
            `SIC_OFF_CTRL: ctrl_nxt = wb_dat_i[7:0];
            `SIC_OFF_HOLD: begin
               // Zero is raised to the smallest level; above run current is capped.
               if (wb_dat_i[6:0] < `SIC_HOLD_MIN) begin
                  hold_nxt = `SIC_HOLD_MIN; // [R02]
               end else if (wb_dat_i[6:0] > `SIC_RUN_PCT) begin
                  hold_nxt = `SIC_RUN_PCT;
               end else begin
                  hold_nxt = wb_dat_i[6:0];
               end
            end
            `SIC_OFF_SSDLY: ssdly_nxt = wb_dat_i[7:0];
            `SIC_OFF_SSFALL: ssfall_nxt = wb_dat_i[7:0];
            `SIC_OFF_LEARN: learn_go_nxt = wb_dat_i[0];
            `SIC_OFF_THR: thr_nxt[7:0] = wb_dat_i[7:0];
            `SIC_OFF_ICLR: istat_nxt = istat_r & ~wb_dat_i[3:0];
            `SIC_OFF_IEN: ien_nxt = wb_dat_i[3:0];
            `SIC_OFF_MODE: mode_nxt = wb_dat_i[2:0];
            default: ;
         endcase
      end
      if (wr && wb_sel_i[1] && wb_adr_i == `SIC_OFF_THR) begin
         thr_nxt[11:8] = wb_dat_i[11:8];
      end
      // A new event wins over a clear in the same cycle.
      istat_nxt = istat_nxt | evt;
      if (rd) begin
         unique case (wb_adr_i)
            `SIC_OFF_CTRL: dat_nxt = {24'h000000, ctrl_r};
            `SIC_OFF_HOLD: dat_nxt = {25'h0000000, hold_r};
            `SIC_OFF_SSDLY: dat_nxt = {24'h000000, ssdly_r};
            `SIC_OFF_SSFALL: dat_nxt = {24'h000000, ssfall_r};
            `SIC_OFF_LEARN: dat_nxt = {31'h00000000, learn_go_r};
            `SIC_OFF_THR: dat_nxt = {20'h00000, thr_r};
            `SIC_OFF_POSA: dat_nxt = {{23{pa_r[8]}}, pa_r}; // [R04]
            `SIC_OFF_POSB: dat_nxt = {{23{pb_r[8]}}, pb_r}; // [R04]
            `SIC_OFF_SCLHI: dat_nxt = {24'h000000, ma_r[9:2]}; // [R07]
            `SIC_OFF_SCLLO: dat_nxt = {30'h00000000, ma_r[1:0]}; // [R07]
            `SIC_OFF_ISTAT: dat_nxt = {28'h0000000, istat_r};
            `SIC_OFF_IEN: dat_nxt = {28'h0000000, ien_r};
            `SIC_OFF_STAT: dat_nxt = {21'h000000, stall_r, 1'b0, ss_r, pct_r};
            `SIC_OFF_LTHR: dat_nxt = {20'h00000, lthr_r};
            `SIC_OFF_MODE: dat_nxt = {29'h00000000, mode_r};
            default: dat_nxt = 32'h0000_0000;
         endcase
      end
      irq_nxt = |(istat_nxt & ien_nxt);
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_r <= `SIC_CTRL_RST; // [R11]
         hold_r <= `SIC_HOLD_RST; // [R01]
         ssdly_r <= `SIC_SSDLY_RST;
         ssfall_r <= `SIC_SSFALL_RST;
         thr_r <= `SIC_THR_RST;
         mode_r <= `SIC_MODE_RST;
         learn_go_r <= 1'b0;
         istat_r <= 4'h0;
         ien_r <= 4'h0;
         ack_r <= 1'b0;
         dat_r <= 32'h0000_0000;
         irq_r <= 1'b0;
      end else begin
         ctrl_r <= ctrl_nxt;
         hold_r <= hold_nxt;
         ssdly_r <= ssdly_nxt;
         ssfall_r <= ssfall_nxt;
         thr_r <= thr_nxt;
         mode_r <= mode_nxt;
         learn_go_r <= learn_go_nxt;
         istat_r <= istat_nxt;
         ien_r <= ien_nxt;
         ack_r <= ack_nxt;
         dat_r <= dat_nxt;
         irq_r <= irq_nxt;
      end
   end

   always_comb begin
      k_nxt = k_r;
      dir_nxt = dir_r;
      per_nxt = (per_r == 16'hFFFF) ? per_r : per_r + 16'h0001;
      ivl_nxt = ivl_r;
      sub_nxt = sub_r;
      rem_nxt = rem_r;
      ss_nxt = ss_r;
      cyc_nxt = cyc_r;
      idle_nxt = idle_r;
      pct_nxt = pct_r;
      lthr_nxt = lthr_r;
      stall_nxt = stall_r;
      evt = 4'h0;
      if (ctrl_r[`SIC_CTRL_IDXRST]) begin
         // The table index and pending substeps are reset here, and the IDXRST interrupt status event is raised.
         k_nxt = `SIC_IDX_HOME; // [R05] [R06]
         rem_nxt = 3'h0;
         evt[`SIC_IRQ_IDXRST] = 1'b1;
      end else if (step_evt) begin
         dir_nxt = dir_s;
         per_nxt = 16'h0000;
         sub_nxt = 16'h0000;
         if (ctrl_r[`SIC_CTRL_AUTO]) begin
            // Substeps still pending from the last pulse are applied at once so no motion is lost.
            k_nxt = kmove(k_r, 10'(fine_inc * ({7'h00, rem_r} + 10'h001)), dir_s); // [R10] [R03]
            rem_nxt = 3'((4'h1 << ares) - 4'h1);
            ivl_nxt = per_r >> ares;
         end else begin
            k_nxt = kmove(k_r, base_inc, dir_s); // [R03]
            rem_nxt = 3'h0;
         end
      end else if (rem_r != 3'h0) begin
         if (sub_r >= ivl_r) begin
            k_nxt = kmove(k_r, fine_inc, dir_r); // [R10]
            rem_nxt = rem_r - 3'h1;
            sub_nxt = 16'h0000;
         end else begin
            sub_nxt = sub_r + 16'h0001;
         end
      end
      kb = kmove(k_nxt, 10'h0FF, 1'b1);
      pa_nxt = pos_of(k_nxt); // [R03] [R04]
      pb_nxt = pos_of(kb); // [R04]
      // Magnitudes depend on table position only, never on any current setting.
      ma_nxt = mag_of(pa_nxt); // [R08] [R09]
      mb_nxt = mag_of(pb_nxt);

      // Standstill current sequencing.
      cyc_nxt = cyc_r + 20'h00001;
      if (step_evt || !ctrl_r[`SIC_CTRL_SSEN]) begin
         ss_nxt = SS_RUN;
         pct_nxt = `SIC_RUN_PCT;
         idle_nxt = 8'h00;
         cyc_nxt = 20'h00000;
      end else begin
         unique case (ss_r)
            SS_RUN: begin
               if (cyc_r >= MS_CYC_W - 20'h00001) begin
                  cyc_nxt = 20'h00000;
                  idle_nxt = (idle_r == 8'hFF) ? idle_r : idle_r + 8'h01;
               end
               if (idle_r >= ssdly_r) begin
                  ss_nxt = SS_FALL; // [R14]
                  cyc_nxt = 20'h00000;
               end
            end
            SS_FALL: begin
               // One percent per hundredth of the fall time reaches hold within it.
               if (pct_r <= hold_r) begin
                  ss_nxt = SS_HOLD; // [R14]
                  pct_nxt = hold_r;
                  evt[`SIC_IRQ_HOLD] = 1'b1;
               end else if (cyc_r >= 20'(ssfall_r * FALL_UNIT)) begin
                  pct_nxt = pct_r - 7'h01; // [R14]
                  cyc_nxt = 20'h00000;
               end
            end
            SS_HOLD: begin
               pct_nxt = hold_r; // [R01]
               cyc_nxt = 20'h00000;
            end
         endcase
      end

      // Stall detection compares torque samples against the active threshold while running.
      if (!ctrl_r[`SIC_CTRL_STALLEN]) begin
         stall_nxt = 1'b0;
      end else if (torque_valid) begin
         if (learn_go_r) begin
            lthr_nxt = torque_count >> 1; // [R13]
            evt[`SIC_IRQ_LEARN] = 1'b1;
         end else if (ss_r == SS_RUN && torque_count < thr_use) begin
            if (!stall_r) begin
               evt[`SIC_IRQ_STALL] = 1'b1; // [R13]
            end
            stall_nxt = 1'b1;
         end else begin
            stall_nxt = 1'b0;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         k_r <= `SIC_IDX_HOME;
         dir_r <= 1'b0;
         per_r <= 16'h0000;
         ivl_r <= 16'h0000;
         sub_r <= 16'h0000;
         rem_r <= 3'h0;
         ss_r <= SS_RUN;
         cyc_r <= 20'h00000;
         idle_r <= 8'h00;
         pct_r <= `SIC_RUN_PCT;
         lthr_r <= `SIC_THR_RST;
         stall_r <= 1'b0;
         pa_r <= 9'sh000;
         pb_r <= 9'sh0FF;
         ma_r <= 10'h000;
         mb_r <= 10'h3FF;
      end else begin
         k_r <= k_nxt;
         dir_r <= dir_nxt;
         per_r <= per_nxt;
         ivl_r <= ivl_nxt;
         sub_r <= sub_nxt;
         rem_r <= rem_nxt;
         ss_r <= ss_nxt;
         cyc_r <= cyc_nxt;
         idle_r <= idle_nxt;
         pct_r <= pct_nxt;
         lthr_r <= lthr_nxt;
         stall_r <= stall_nxt;
         pa_r <= pa_nxt;
         pb_r <= pb_nxt;
         ma_r <= ma_nxt;
         mb_r <= mb_nxt;
      end
   end

   assign wb_ack_o = ack_r;
   assign wb_dat_o = dat_r;
   assign irq = irq_r;
   assign pos_a = pa_r;
   assign pos_b = pb_r;
   assign phase_a_mag = ma_r;
   assign phase_b_mag = mb_r;
   assign current_pct = pct_r;
   assign stall = stall_r;
endmodule

// *** verilog/sic_params.svh ***
// Purpose: Offsets, field positions, reset values and timing counts of the stepper indexer.
// Assumes: 32-bit classic Wishbone, byte addresses, one register per aligned word.
// Notes: Timing counts derive from the clock period below.
`ifndef SIC_PARAMS_SVH
`define SIC_PARAMS_SVH
`define SIC_CLK_NS 4
`define SIC_MS_NS 1000000
`define SIC_FALL_UNIT_NS 10000
`define SIC_FALL_UNIT_CYC ((`SIC_FALL_UNIT_NS + `SIC_CLK_NS - 1) / `SIC_CLK_NS)
`define SIC_MS_CYC ((`SIC_MS_NS + `SIC_CLK_NS - 1) / `SIC_CLK_NS)
`define SIC_OFF_CTRL 8'h00
`define SIC_OFF_HOLD 8'h04
`define SIC_OFF_SSDLY 8'h08
`define SIC_OFF_SSFALL 8'h0C
`define SIC_OFF_LEARN 8'h10
`define SIC_OFF_THR 8'h14
`define SIC_OFF_POSA 8'h18
`define SIC_OFF_POSB 8'h1C
`define SIC_OFF_SCLHI 8'h20
`define SIC_OFF_SCLLO 8'h24
`define SIC_OFF_ISTAT 8'h28
`define SIC_OFF_ICLR 8'h2C
`define SIC_OFF_IEN 8'h30
`define SIC_OFF_STAT 8'h34
`define SIC_OFF_LTHR 8'h38
`define SIC_OFF_MODE 8'h3C
`define SIC_CTRL_IDXRST 0
`define SIC_CTRL_BOTH 1
`define SIC_CTRL_AUTO 2
`define SIC_CTRL_ARES_LO 3
`define SIC_CTRL_SSEN 5
`define SIC_CTRL_STALLEN 6
`define SIC_CTRL_LEARNEN 7
`define SIC_IRQ_STALL 0
`define SIC_IRQ_HOLD 1
`define SIC_IRQ_IDXRST 2
`define SIC_IRQ_LEARN 3
`define SIC_CTRL_RST 8'h00
`define SIC_HOLD_RST 7'h32
`define SIC_HOLD_MIN 7'h01
`define SIC_RUN_PCT 7'h64
`define SIC_SSDLY_RST 8'h40
`define SIC_SSFALL_RST 8'h40
`define SIC_THR_RST 12'h000
`define SIC_MODE_RST 3'h7
`define SIC_IDX_HOME 10'h000
`define SIC_IDX_PERIOD 10'h3FC
`endif

// *** verilog/sic_pkg.sv ***
// Purpose: Types shared by the stepper indexer files.
// Assumes: Constants live in sic_params.svh.
// Notes: Standstill current sequencing states.
package sic_pkg;
   typedef enum logic [1:0] {SS_RUN, SS_FALL, SS_HOLD} sic_ss_e;
   typedef logic signed [8:0] sic_pos_t;
endpackage

// *** verilog/sic_step_in.sv ***
// Purpose: Synchronise step and direction pins and turn step edges into one-cycle events.
// Assumes: Pins are asynchronous to clk.
// Notes: Only the second synchroniser stage feeds the edge detector.
`timescale 1ns/1ps
module sic_step_in (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic step_pin,
   input wire logic dir_pin,
   input wire logic both_edges,
   output logic step_evt,
   output logic dir_s
);
   logic [1:0] step_sync_r;
   logic [1:0] dir_sync_r;
   logic step_prev_r;
   logic [1:0] step_sync_nxt;
   logic [1:0] dir_sync_nxt;
   logic step_prev_nxt;

   always_comb begin
      step_sync_nxt = {step_sync_r[0], step_pin};
      dir_sync_nxt = {dir_sync_r[0], dir_pin};
      step_prev_nxt = step_sync_r[1];
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         step_sync_r <= 2'h0;
         dir_sync_r <= 2'h0;
         step_prev_r <= 1'b0;
      end else begin
         step_sync_r <= step_sync_nxt;
         dir_sync_r <= dir_sync_nxt;
         step_prev_r <= step_prev_nxt;
      end
   end

   // Falling edges count only when both-edge stepping is selected.
   assign step_evt = both_edges ? (step_sync_r[1] ^ step_prev_r) : (step_sync_r[1] & ~step_prev_r); // [R11]
   assign dir_s = dir_sync_r[1];
endmodule

// *** sim/sic_checker.sv ***
// Purpose: Port assertions for the stepper indexer.
// Assumes: One clock domain with asynchronous active-low reset.
// Notes: Bound to every sic_indexer instance.
`timescale 1ns/1ps
module sic_checker (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire sic_pkg::sic_pos_t pos_a,
   input wire sic_pkg::sic_pos_t pos_b,
   input wire logic [9:0] phase_a_mag,
   input wire logic [6:0] current_pct
);
   import sic_pkg::*;
   int amp_sum;
   // Quarter-period offset makes the two absolute positions always add up to the peak.
   always_comb amp_sum = (pos_a < 0 ? -int'(pos_a) : int'(pos_a)) + (pos_b < 0 ? -int'(pos_b) : int'(pos_b));
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held too long");
   a_ack_answers: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("no ack one cycle after request");
   a_dat_idle_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
      else $error("read data outside ack");
   a_pos_in_range: assert property (pos_a <= 255 && pos_a >= -255)
      else $error("position out of range");
   a_phase_pair: assert property (amp_sum == 255)
      else $error("phase positions not a quarter apart");
   a_mag_home: assert property (pos_a == 0 |-> phase_a_mag == 10'h000)
      else $error("scaler not zero at home");
   a_mag_peak: assert property (pos_a == 255 || pos_a == -255 |-> phase_a_mag == 10'h3FF)
      else $error("scaler not full at peak");
   a_pct_floor: assert property (current_pct >= 7'h01 && current_pct <= 7'h64)
      else $error("current percent out of range");
   a_pct_ramp: assert property (current_pct < $past(current_pct) |-> current_pct == $past(current_pct) - 7'h01)
      else $error("current fell by more than one");
   a_pct_restore: assert property (current_pct > $past(current_pct) |-> current_pct == 7'h64)
      else $error("current rise not to full run");
endmodule

bind sic_indexer sic_checker chk_i (.clk(clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pos_a(pos_a), .pos_b(pos_b), .phase_a_mag(phase_a_mag),
   .current_pct(current_pct));

// *** sim/sic_mcu_model.sv ***
// Purpose: Controller model that drives the step and direction pins.
// Assumes: Pulse halves of at least three clocks.
// Notes: Direction is set and allowed to settle before the first edge.
`timescale 1ns/1ps
module sic_mcu_model (
   input wire logic clk,
   output logic step_pin,
   output logic dir_pin
);
   initial begin
      step_pin = 1'b0;
      dir_pin = 1'b1;
   end
   task automatic pulses(input int n, input int half, input logic both, input logic fwd);
      @(posedge clk);
      dir_pin <= fwd;
      repeat (4) @(posedge clk);
      for (int i = 0; i < n; i++) begin
         if (both) begin
            // Each edge is a step, so the pin toggles at half the rate.
            step_pin <= ~step_pin;
            repeat (2 * half) @(posedge clk);
         end else begin
            step_pin <= 1'b1;
            repeat (half) @(posedge clk);
            step_pin <= 1'b0;
            repeat (half) @(posedge clk);
         end
      end
   endtask
endmodule

// *** sim/tb.sv ***
// Purpose: Self-checking bench for the stepper indexer.
// Assumes: MS_CYC shortened to 20 cycles.
// Notes: Positions are compared as raw 9-bit patterns.
`timescale 1ns/1ps
`include "sic_params.svh"
module tb;
   import sic_pkg::*;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic we = 1'b0;
   logic tv = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [31:0] wd = 32'h0;
   logic [11:0] tq = 12'h000;
   logic [31:0] rd, dat_o;
   logic ack, step, dir, stall, irq;
   sic_pos_t pos_a, pos_b;
   logic [9:0] mag_a;
   logic [9:0] mag_b;
   logic [6:0] pct;
   int fail_count = 0;
   int checked = 0;
   int n;
   always #2 clk = ~clk;
   sic_mcu_model mcu (.clk(clk), .step_pin(step), .dir_pin(dir));
   sic_indexer #(.MS_CYC(20)) uut (.clk(clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wd), .wb_dat_o(dat_o), .wb_ack_o(ack), .step_pin(step),
      .dir_pin(dir), .torque_count(tq), .torque_valid(tv), .pos_a(pos_a), .pos_b(pos_b), .phase_a_mag(mag_a),
      .phase_b_mag(mag_b), .current_pct(pct), .stall(stall), .irq(irq));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      checked++;
      if (got !== exp) begin
         fail_count++;
         $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      k = 0;
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wd <= d;
      do begin
         @(posedge clk);
         k++;
      end while (ack !== 1'b1 && k < 20);
      rd = dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
      if (k >= 20) chk(32'h0, 32'h1, "bus answer");
   endtask
   task automatic rc(input logic [7:0] a, input logic [31:0] e, input string what);
      bus(1'b0, a, 32'h0);
      chk(rd, e, what);
   endtask
   task automatic torque(input logic [11:0] v);
      @(posedge clk);
      tq <= v;
      tv <= 1'b1;
      @(posedge clk);
      tv <= 1'b0;
      repeat (3) @(posedge clk);
   endtask
   task automatic endt(input string s);
      $display("Done %s: %0d checks, %0d mismatches", s, checked, fail_count);
   endtask
   task automatic wrap_up();
      $display("Comparisons %0d, mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   initial begin
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      chk({23'h0, pos_b}, 32'hFF, "b home");
      chk({22'h0, mag_b}, 32'h3FF, "b magnitude home");
      rc(`SIC_OFF_MODE, 32'h7, "mode default");
      rc(`SIC_OFF_HOLD, 32'h32, "hold default");
      rc(`SIC_OFF_CTRL, 32'h0, "ctrl default");
      rc(8'h40, 32'h0, "unmapped");
      bus(1'b1, `SIC_OFF_HOLD, 32'h0);
      rc(`SIC_OFF_HOLD, 32'h1, "hold floor");
      endt("registers");
      mcu.pulses(255, 4, 1'b0, 1'b1);
      repeat (6) @(posedge clk);
      chk({23'h0, pos_a}, 32'hFF, "a peak");
      rc(`SIC_OFF_SCLHI, 32'hFF, "scaler high");
      rc(`SIC_OFF_SCLLO, 32'h3, "scaler low");
      mcu.pulses(255, 4, 1'b0, 1'b1);
      repeat (6) @(posedge clk);
      chk({23'h0, pos_b}, 32'h101, "b trough");
      endt("stepping");
      bus(1'b1, `SIC_OFF_IEN, 32'h4);
      bus(1'b1, `SIC_OFF_CTRL, 32'h3);
      rc(`SIC_OFF_CTRL, 32'h2, "self clear");
      chk({23'h0, pos_b}, 32'hFF, "b reset");
      rc(`SIC_OFF_HOLD, 32'h1, "hold kept");
      chk({31'h0, irq}, 32'h1, "irq raised");
      bus(1'b1, `SIC_OFF_IEN, 32'h0);
      repeat (3) @(posedge clk);
      chk({31'h0, irq}, 32'h0, "irq masked");
      rc(`SIC_OFF_ISTAT, 32'h4, "status sticky");
      bus(1'b1, `SIC_OFF_ICLR, 32'h4);
      rc(`SIC_OFF_ISTAT, 32'h0, "status cleared");
      endt("indexer reset");
      mcu.pulses(2, 4, 1'b1, 1'b1);
      repeat (6) @(posedge clk);
      chk({23'h0, pos_a}, 32'h2, "both edges");
      bus(1'b1, `SIC_OFF_CTRL, 32'h0);
      mcu.pulses(3, 4, 1'b0, 1'b0);
      repeat (6) @(posedge clk);
      chk({23'h0, pos_a}, 32'h1FF, "a reverse");
      chk({23'h0, pos_b}, 32'hFE, "b reverse");
      bus(1'b1, `SIC_OFF_MODE, 32'h6);
      mcu.pulses(1, 4, 1'b0, 1'b1);
      repeat (6) @(posedge clk);
      chk({23'h0, pos_a}, 32'h1, "coarse mode step");
      bus(1'b1, `SIC_OFF_MODE, 32'h7);
      bus(1'b1, `SIC_OFF_CTRL, 32'hD);
      mcu.pulses(4, 8, 1'b0, 1'b1);
      repeat (100) @(posedge clk);
      chk({23'h0, pos_a}, 32'h8, "auto substeps");
      endt("edges");
      bus(1'b1, `SIC_OFF_THR, 32'h64);
      bus(1'b1, `SIC_OFF_CTRL, 32'h40);
      torque(12'h032);
      chk({31'h0, stall}, 32'h1, "manual stall");
      torque(12'h12C);
      chk({31'h0, stall}, 32'h0, "no stall");
      bus(1'b1, `SIC_OFF_LEARN, 32'h1);
      bus(1'b1, `SIC_OFF_CTRL, 32'hC0);
      torque(12'h190);
      rc(`SIC_OFF_LTHR, 32'hC8, "learned");
      torque(12'h096);
      chk({31'h0, stall}, 32'h1, "learned stall");
      endt("stall");
      bus(1'b1, `SIC_OFF_ICLR, 32'hF);
      bus(1'b1, `SIC_OFF_HOLD, 32'h62);
      bus(1'b1, `SIC_OFF_SSDLY, 32'h1);
      bus(1'b1, `SIC_OFF_SSFALL, 32'h1);
      bus(1'b1, `SIC_OFF_CTRL, 32'h20);
      chk({25'h0, pct}, 32'h64, "run before delay");
      n = 0;
      while (pct !== 7'h62 && n < 12000) begin
         @(posedge clk);
         n++;
      end
      chk({25'h0, pct}, 32'h62, "hold reached");
      rc(`SIC_OFF_ISTAT, 32'h2, "hold status");
      mcu.pulses(1, 4, 1'b0, 1'b1);
      repeat (2) @(posedge clk);
      chk({25'h0, pct}, 32'h64, "run on step");
      endt("standstill");
      wrap_up();
   end
   initial begin
      repeat (60000) @(posedge clk);
      fail_count++;
      $display("Error at %0t: watchdog expired", $time);
      wrap_up();
   end
endmodule
